// *** src/ecdma_pkg.sv ***
// constants, encodings and helpers shared by the eight-channel dma files
package ecdma_pkg;

  localparam int NCH = 8;
  localparam int CW  = 3;
  localparam int AW  = 12;

  // per-channel register window: channel index in paddr[6:4]
  localparam logic [3:0]    REG_CTRL  = 4'h0;
  localparam logic [3:0]    REG_PBASE = 4'h4;
  localparam logic [3:0]    REG_MBASE = 4'h8;
  localparam logic [3:0]    REG_COUNT = 4'hC;
  // global registers
  localparam logic [AW-1:0] OFS_FLAGS   = 12'h080;
  localparam logic [AW-1:0] OFS_FLAGCLR = 12'h084;
  localparam logic [AW-1:0] OFS_SWTRIG  = 12'h088;

  // channel control field positions
  localparam int CTL_EN     = 0;
  localparam int CTL_ALLIE  = 1;
  localparam int CTL_HALFIE = 2;
  localparam int CTL_DIR    = 3;
  localparam int CTL_WRAP   = 4;
  localparam int CTL_PSTEP  = 5;
  localparam int CTL_MSTEP  = 6;
  localparam int CTL_PW_LO  = 8;
  localparam int CTL_MW_LO  = 10;
  localparam int CTL_PRI_LO = 12;
  localparam int CTL_M2M    = 14;
  localparam logic [15:0] CTL_MASK = 16'h7F7F;

  // flag register layout
  localparam int FLG_ALL_LO  = 0;
  localparam int FLG_HALF_LO = 8;

  // reset values
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [31:0] ADDR_RST  = 32'h00000000;
  localparam logic [15:0] COUNT_RST = 16'h0000;

  // transfer widths
  localparam logic [1:0] W_BYTE = 2'h0;
  localparam logic [1:0] W_HALF = 2'h1;
  localparam logic [1:0] W_WORD = 2'h2;

  // software priority levels
  localparam logic [1:0] PRI_LOW   = 2'h0;
  localparam logic [1:0] PRI_MED   = 2'h1;
  localparam logic [1:0] PRI_HIGH  = 2'h2;
  localparam logic [1:0] PRI_VHIGH = 2'h3;

  typedef enum logic [1:0] {
    PH_IDLE  = 2'h0,
    PH_READ  = 2'h1,
    PH_WRITE = 2'h3
  } ecdma_fsm_t;

  function automatic logic [31:0] ecdma_step(input logic [1:0] w);
    if (w == W_BYTE)
      return 32'h00000001;
    else if (w == W_HALF)
      return 32'h00000002;
    else
      return 32'h00000004;
  endfunction

  function automatic logic [31:0] ecdma_mask(input logic [1:0] w);
    if (w == W_BYTE)
      return 32'h000000FF;
    else if (w == W_HALF)
      return 32'h0000FFFF;
    else
      return 32'hFFFFFFFF;
  endfunction

endpackage

// *** src/ecdma_arb_if.sv ***
// pending requests and priorities to the arbiter, grant back
`timescale 1ns/1ps
interface ecdma_arb_if;
  logic [ecdma_pkg::NCH-1:0]      pending;
  logic [ecdma_pkg::NCH-1:0][1:0] prio;
  logic                           grant_valid;
  logic [ecdma_pkg::CW-1:0]       grant_idx;

  modport arb
  (
    input  pending,
    input  prio,
    output grant_valid,
    output grant_idx
  );
  modport ctl
  (
    output pending,
    output prio,
    input  grant_valid,
    input  grant_idx
  );
endinterface

// *** src/ecdma_arb.sv ***
// two-stage channel arbiter: software priority, then lowest index
`timescale 1ns/1ps
module ecdma_arb (
  ecdma_arb_if.arb port
);
  import ecdma_pkg::*;

  logic           found;
  logic [1:0]     best_pri;
  logic [CW-1:0]  best_idx;

  // walk downward so an equal level later in the loop, lower index, wins
  always_comb
  begin
    found    = 1'b0;
    best_pri = PRI_LOW;
    best_idx = '0;
    for (int c = NCH - 1; c >= 0; c--)
    begin
      if (port.pending[c] && (!found || port.prio[c] >= best_pri))
      begin
        found    = 1'b1;
        best_pri = port.prio[c];
        best_idx = CW'(c);
      end
    end
  end

  assign port.grant_valid = found;
  assign port.grant_idx   = best_idx;

  function automatic logic beaten(input int c);
    return port.pending[c] &&
      (port.prio[c] > port.prio[best_idx] ||
       (port.prio[c] == port.prio[best_idx] && CW'(c) < best_idx));
  endfunction

  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      chk_prio_winner: assert final (!(found && beaten(c)))
        else $error("arbiter granted a channel that another outranks");
    end
    chk_grant_pending: assert final (!found || port.pending[best_idx])
      else $error("arbiter granted a channel that is not pending");
  end
endmodule

// *** src/ecdma_top.sv ***
// eight-channel dma controller with apb registers and a bus master port
//
// Summary of operation
// - eight channels, each with a hardware request line and software trigger
// - each channel has a four-level software priority, first arbiter stage
// - on equal priority the lower channel index is granted
// - source and destination widths chosen separately; data zero-extended or cut
// - half and complete flags ORed into one interrupt output per channel
// - item count up to 65535, decremented after every transaction
// - bus reached via an outside round-robin matrix; master waits on ready
// - ack raised on access, held until the peripheral drops its request
// - each transaction reads source, writes destination, then counts down
// - base registers start a transfer, keep their value; pointers hidden
// - enabled increment advances a pointer by 1, 2 or 4 per that width
// - without circular mode a channel at count zero serves no request
// - disabling a channel keeps control, base address and count values
// - circular mode reloads count and both pointers, then continues
// - half the items done sets the half flag, interrupt if enabled
// - transfer end sets the complete flag, interrupt if enabled
// - memory-to-memory runs once enabled without request, stops at zero unless circular
// - supports peripheral/memory in any pairing, memory-to-memory for ram
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module ecdma_top (
  input  wire logic                       mclk,
  input  wire logic                       sys_rst,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [ecdma_pkg::AW-1:0]   paddr,
  input  wire logic [31:0]                pwdata,
  output wire logic [31:0]                prdata,
  output wire logic                       pready,
  output wire logic                       pslverr,
  output wire logic                       bus_req,
  output wire logic                       bus_write,
  output wire logic [31:0]                bus_addr,
  output wire logic [1:0]                 bus_size,
  output wire logic [31:0]                bus_wdata,
  input  wire logic [31:0]                bus_rdata,
  input  wire logic                       bus_ready,
  input  wire logic [ecdma_pkg::NCH-1:0]  dreq,
  output wire logic [ecdma_pkg::NCH-1:0]  dack,
  output wire logic [ecdma_pkg::NCH-1:0]  chan_irq
);
  import ecdma_pkg::*;

  typedef struct packed {
    logic [NCH-1:0][15:0] ctrl;
    logic [NCH-1:0][31:0] pbase;
    logic [NCH-1:0][31:0] mbase;
    logic [NCH-1:0][31:0] pcur;
    logic [NCH-1:0][31:0] mcur;
    logic [NCH-1:0][15:0] count;
    logic [NCH-1:0][15:0] init_cnt;
    logic [NCH-1:0]       half_flag;
    logic [NCH-1:0]       all_flag;
    logic [NCH-1:0]       sw_pend;
    logic [NCH-1:0]       ack;
    logic [NCH-1:0]       irq;
    logic [NCH-1:0]       dreq_s1;
    logic [NCH-1:0]       dreq_s2;
    ecdma_fsm_t           phase;
    logic [CW-1:0]        ch;
    logic                 bus_req;
    logic                 bus_write;
    logic [31:0]          bus_addr;
    logic [1:0]           bus_size;
    logic [31:0]          bus_wdata;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
  } ecdma_regs_t;

  ecdma_regs_t     r;
  ecdma_regs_t     next_r;

  ecdma_arb_if     arb_bus ();

  ecdma_arb u_arb (
    .port (arb_bus.arb)
  );

  logic            in_chan;
  logic [CW-1:0]   asel;
  logic            apb_wr;
  logic            apb_setup;
  logic [NCH-1:0]  pend;
  logic [NCH-1:0]  hie;
  logic [NCH-1:0]  aie;
  logic [15:0]     cur_ctrl;
  logic [15:0]     gnt_ctrl;
  logic [1:0]      src_w;
  logic [1:0]      dst_w;
  logic [15:0]     dec_cnt;

  // address decode shared by the read and write paths
  always_comb
  begin
    in_chan   = (paddr[AW-1:7] == 5'h00);
    asel      = paddr[6:4];
    apb_wr    = psel && penable && r.pready && pwrite;
    apb_setup = psel && !penable;
    cur_ctrl  = r.ctrl[r.ch];
    gnt_ctrl  = r.ctrl[arb_bus.grant_idx];
    src_w     = cur_ctrl[CTL_DIR] ? cur_ctrl[CTL_MW_LO +: 2]
                                  : cur_ctrl[CTL_PW_LO +: 2];
    dst_w     = cur_ctrl[CTL_DIR] ? cur_ctrl[CTL_PW_LO +: 2]
                                  : cur_ctrl[CTL_MW_LO +: 2];
    dec_cnt   = r.count[r.ch] - 16'h0001;
    for (int c = 0; c < NCH; c++)
    begin
      hie[c]  = r.ctrl[c][CTL_HALFIE];
      aie[c]  = r.ctrl[c][CTL_ALLIE];
      // an empty channel is never offered to the arbiter
      pend[c] = r.ctrl[c][CTL_EN] && (r.count[c] != 16'h0000) &&
                (r.ctrl[c][CTL_M2M] || r.sw_pend[c] ||
                 (r.dreq_s2[c] && !r.ack[c]));
    end
  end

  always_comb
  begin
    arb_bus.pending = (r.phase == PH_IDLE) ? pend : '0;
    for (int c = 0; c < NCH; c++)
    begin
      arb_bus.prio[c] = r.ctrl[c][CTL_PRI_LO +: 2];
    end
  end

  always_comb
  begin
    next_r         = r;
    next_r.dreq_s1 = dreq;
    next_r.dreq_s2 = r.dreq_s1;

    // clear before set so a flag raised in the same cycle survives
    if (apb_wr && paddr == OFS_FLAGCLR)
    begin
      next_r.all_flag  = r.all_flag & ~pwdata[FLG_ALL_LO +: NCH];
      next_r.half_flag = r.half_flag & ~pwdata[FLG_HALF_LO +: NCH];
    end

    for (int c = 0; c < NCH; c++)
    begin
      if (r.ack[c] && !r.dreq_s2[c])
        next_r.ack[c] = 1'b0;
    end

    case (r.phase)
      PH_IDLE:
      begin
        if (arb_bus.grant_valid)
        begin
          next_r.ch = arb_bus.grant_idx;
          if (r.sw_pend[arb_bus.grant_idx])
            next_r.sw_pend[arb_bus.grant_idx] = 1'b0;
          else if (!gnt_ctrl[CTL_M2M])
            next_r.ack[arb_bus.grant_idx] = 1'b1;
          next_r.bus_req   = 1'b1;
          next_r.bus_write = 1'b0;
          next_r.bus_addr  = gnt_ctrl[CTL_DIR] ?
                             r.mcur[arb_bus.grant_idx] :
                             r.pcur[arb_bus.grant_idx];
          next_r.bus_size  = gnt_ctrl[CTL_DIR] ?
                             gnt_ctrl[CTL_MW_LO +: 2] :
                             gnt_ctrl[CTL_PW_LO +: 2];
          next_r.phase     = PH_READ;
        end
      end
      PH_READ:
      begin
        if (bus_ready)
        begin
          // narrow source zero-extends, narrow destination keeps low lanes
          next_r.bus_wdata = bus_rdata & ecdma_mask(src_w) &
                             ecdma_mask(dst_w);
          next_r.bus_write = 1'b1;
          next_r.bus_size  = dst_w;
          next_r.bus_addr  = cur_ctrl[CTL_DIR] ? r.pcur[r.ch]
                                               : r.mcur[r.ch];
          next_r.phase     = PH_WRITE;
        end
      end
      PH_WRITE:
      begin
        if (bus_ready)
        begin
          next_r.bus_req   = 1'b0;
          next_r.bus_write = 1'b0;
          next_r.phase     = PH_IDLE;
          if (cur_ctrl[CTL_PSTEP])
            next_r.pcur[r.ch] = r.pcur[r.ch] +
              ecdma_step(cur_ctrl[CTL_PW_LO +: 2]);
          if (cur_ctrl[CTL_MSTEP])
            next_r.mcur[r.ch] = r.mcur[r.ch] +
              ecdma_step(cur_ctrl[CTL_MW_LO +: 2]);
          next_r.count[r.ch] = dec_cnt;
          if (dec_cnt == (r.init_cnt[r.ch] >> 1))
            next_r.half_flag[r.ch] = 1'b1;
          if (dec_cnt == 16'h0000)
          begin
            next_r.all_flag[r.ch] = 1'b1;
            if (cur_ctrl[CTL_WRAP])
            begin
              next_r.count[r.ch] = r.init_cnt[r.ch];
              next_r.pcur[r.ch]  = r.pbase[r.ch];
              next_r.mcur[r.ch]  = r.mbase[r.ch];
            end
          end
        end
      end
      default:
        next_r.phase = PH_IDLE;
    endcase

    // register writes take effect at the access edge only
    if (apb_wr)
    begin
      if (in_chan && paddr[3:0] == REG_CTRL)
      begin
        next_r.ctrl[asel] = pwdata[15:0] & CTL_MASK;
        // enabling restarts the hidden pointers from the bases
        if (pwdata[CTL_EN] && !r.ctrl[asel][CTL_EN])
        begin
          next_r.pcur[asel] = r.pbase[asel];
          next_r.mcur[asel] = r.mbase[asel];
        end
      end
      else if (in_chan && paddr[3:0] == REG_PBASE)
        next_r.pbase[asel] = pwdata;
      else if (in_chan && paddr[3:0] == REG_MBASE)
        next_r.mbase[asel] = pwdata;
      else if (in_chan && paddr[3:0] == REG_COUNT)
      begin
        // a count written to a running channel is dropped
        if (!r.ctrl[asel][CTL_EN])
        begin
          next_r.count[asel]    = pwdata[15:0];
          next_r.init_cnt[asel] = pwdata[15:0];
        end
      end
      else if (paddr == OFS_SWTRIG)
        next_r.sw_pend = next_r.sw_pend | pwdata[NCH-1:0];
    end

    // zero-wait slave: answer prepared in setup, shown in access
    next_r.pready  = apb_setup;
    next_r.pslverr = 1'b0;
    if (apb_setup)
    begin
      next_r.prdata = 32'h00000000;
      if (paddr[1:0] != 2'h0)
        next_r.pslverr = 1'b1;
      else if (in_chan && paddr[3:0] == REG_CTRL)
        next_r.prdata = {16'h0000, r.ctrl[asel]};
      else if (in_chan && paddr[3:0] == REG_PBASE)
        next_r.prdata = r.pbase[asel];
      else if (in_chan && paddr[3:0] == REG_MBASE)
        next_r.prdata = r.mbase[asel];
      else if (in_chan && paddr[3:0] == REG_COUNT)
        next_r.prdata = {16'h0000, r.count[asel]};
      else if (paddr == OFS_FLAGS)
        next_r.prdata = {16'h0000, r.half_flag, r.all_flag};
      else if (paddr == OFS_FLAGCLR || paddr == OFS_SWTRIG)
        next_r.prdata = {24'h000000, r.sw_pend};
      else
        next_r.pslverr = 1'b1;
    end

    for (int c = 0; c < NCH; c++)
    begin
      next_r.irq[c] =
        (next_r.half_flag[c] && next_r.ctrl[c][CTL_HALFIE]) ||
        (next_r.all_flag[c] && next_r.ctrl[c][CTL_ALLIE]);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      r <= '0;
    else
      r <= next_r;
  end

  assign prdata    = r.prdata;
  assign pready    = r.pready;
  assign pslverr   = r.pslverr;
  assign bus_req   = r.bus_req;
  assign bus_write = r.bus_write;
  assign bus_addr  = r.bus_addr;
  assign bus_size  = r.bus_size;
  assign bus_wdata = r.bus_wdata;
  assign dack      = r.ack;
  assign chan_irq  = r.irq;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence s_read_done;
    r.phase == PH_READ && bus_ready;
  endsequence

  sequence s_write_issued;
    r.phase == PH_WRITE && r.bus_write && r.bus_req;
  endsequence

  chk_read_write: assert property (s_read_done |=> s_write_issued)
    else $error("read completion not followed by a write");

  chk_ack_hold: assert property (
    (r.ack & r.dreq_s2) != 8'h00 |=>
      (r.ack & $past(r.ack & r.dreq_s2)) == $past(r.ack & r.dreq_s2))
    else $error("ack dropped while request still high");

  chk_count_dec: assert property (
    r.phase == PH_WRITE && bus_ready && r.count[r.ch] != 16'h0001 |=>
      r.count[$past(r.ch)] == $past(r.count[r.ch]) - 16'h0001)
    else $error("count not decremented by one");

  chk_circular_en_reload: assert property (
    r.phase == PH_WRITE && bus_ready && r.count[r.ch] == 16'h0001 &&
    cur_ctrl[CTL_WRAP] |=>
      r.count[$past(r.ch)] == r.init_cnt[$past(r.ch)] &&
      r.pcur[$past(r.ch)] == r.pbase[$past(r.ch)] &&
      r.mcur[$past(r.ch)] == r.mbase[$past(r.ch)])
    else $error("circular reload missing");

  chk_zero_idle: assert property (
    r.phase == PH_IDLE && arb_bus.grant_valid |->
      r.count[arb_bus.grant_idx] != 16'h0000)
    else $error("empty channel was granted");

  chk_pptr_step: assert property (
    r.phase == PH_WRITE && bus_ready && cur_ctrl[CTL_PSTEP] &&
    r.count[r.ch] != 16'h0001 |=>
      r.pcur[$past(r.ch)] == $past(r.pcur[r.ch]) +
        ecdma_step($past(cur_ctrl[CTL_PW_LO +: 2])))
    else $error("peripheral pointer step wrong");

  chk_irq_map: assert property (
    ##1 r.irq == ((r.half_flag & hie) | (r.all_flag & aie)))
    else $error("channel interrupt does not match flags");

  chk_half_flag: assert property (
    r.phase == PH_WRITE && bus_ready &&
    dec_cnt == (r.init_cnt[r.ch] >> 1) |=> r.half_flag[$past(r.ch)])
    else $error("half flag not set");

  chk_done_flag: assert property (
    r.phase == PH_WRITE && bus_ready && dec_cnt == 16'h0000 |=>
      r.all_flag[$past(r.ch)])
    else $error("complete flag not set");

  chk_m2m_noack: assert property (
    r.phase == PH_IDLE && arb_bus.grant_valid && gnt_ctrl[CTL_M2M] &&
    !r.ack[arb_bus.grant_idx] |=> !r.ack[r.ch])
    else $error("memory to memory transfer raised ack");

  chk_base_keep: assert property (
    r.phase != PH_IDLE && !apb_wr |=> $stable(r.pbase) && $stable(r.mbase))
    else $error("base address changed by a transfer");

  chk_width_pack: assert property (
    s_write_issued |-> (r.bus_wdata & ~ecdma_mask(r.bus_size)) == 32'h0)
    else $error("write data wider than destination width");

  chk_req_hold: assert property (
    r.bus_req && !bus_ready |=> r.bus_req && $stable(r.bus_addr))
    else $error("bus request released before ready");
endmodule

// *** testbench/ecdma_far_model.sv ***
// bus memory slave and per-channel peripheral request model
`timescale 1ns/1ps
module ecdma_far_model (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        bus_req,
  input  wire logic        bus_write,
  input  wire logic [31:0] bus_addr,
  input  wire logic [1:0]  bus_size,
  input  wire logic [31:0] bus_wdata,
  input  wire logic [7:0]  dack,
  input  wire logic [7:0]  kick,
  input  wire logic [3:0]  dly,
  output logic      [31:0] bus_rdata,
  output logic             bus_ready,
  output logic      [7:0]  dreq
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] wa [$];
  logic [31:0] wd [$];
  logic [1:0]  wz [$];
  logic [3:0]  cnt;
  int          pend [8];

  function automatic logic [31:0] rdv(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : a ^ 32'h5A5A0000;
  endfunction

  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      bus_ready <= 1'b0;
      bus_rdata <= 32'h00000000;
      cnt       <= 4'h0;
      dreq      <= 8'h00;
    end
    else
    begin
      // released data lines flip so a stale word is never mistaken
      if (bus_ready)
      begin
        bus_ready <= 1'b0;
        cnt       <= 4'h0;
        bus_rdata <= ~bus_rdata;
        if (bus_write)
        begin
          mem[bus_addr] = bus_wdata;
          wa.push_back(bus_addr);
          wd.push_back(bus_wdata);
          wz.push_back(bus_size);
        end
      end
      else if (bus_req)
      begin
        if (cnt >= dly)
        begin
          bus_ready <= 1'b1;
          bus_rdata <= rdv(bus_addr);
        end
        else
          cnt <= cnt + 4'h1;
      end
      for (int c = 0; c < 8; c++)
      begin
        pend[c] = pend[c] + int'(kick[c]);
        if (dreq[c] && dack[c])
          dreq[c] <= 1'b0;
        else if (!dreq[c] && !dack[c] && pend[c] > 0)
        begin
          dreq[c] <= 1'b1;
          pend[c] = pend[c] - 1;
        end
      end
    end
  end
endmodule

// *** testbench/ecdma_bench.sv ***
// self-checking bench for the eight-channel dma controller
`timescale 1ns/1ps
module ecdma_bench;
  import ecdma_pkg::*;
  logic        mclk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        bus_req;
  logic        bus_write;
  logic [31:0] bus_addr;
  logic [1:0]  bus_size;
  logic [31:0] bus_wdata;
  logic [31:0] bus_rdata;
  logic        bus_ready;
  logic [7:0]  dreq;
  logic [7:0]  dack;
  logic [7:0]  chan_irq;
  logic [7:0]  kick;
  logic [3:0]  dly;
  int          miscompares;
  int          checks;
  logic [31:0] r;
  logic        e;
  logic [1:0]  pt [4][2];
  logic [31:0] first [4];

  ecdma_top u_ecdma_top (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr),
    .bus_size(bus_size), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_ready(bus_ready), .dreq(dreq), .dack(dack), .chan_irq(chan_irq));

  ecdma_far_model u_ecdma_far_model (.mclk(mclk), .sys_rst(sys_rst),
    .bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr),
    .bus_size(bus_size),
    .bus_wdata(bus_wdata), .dack(dack), .kick(kick), .dly(dly),
    .bus_rdata(bus_rdata), .bus_ready(bus_ready), .dreq(dreq));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x)
    begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, g, x);
    end
  endtask

  // waits on pready, never on a fixed count
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never gets an answer
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h00000000);
    chk(r, x);
  endtask

  function automatic logic [11:0] ra(input int n, input logic [3:0] o);
    return 12'(n * 16) + {8'h00, o};
  endfunction

  task automatic wait_log(input int n);
    for (int i = 0; i < 2000 && u_ecdma_far_model.wa.size() < n; i++)
      @(posedge mclk);
    chk(32'(u_ecdma_far_model.wa.size()), 32'(n));
  endtask

  task automatic setup(input int c, input logic [31:0] pb,
                       input logic [31:0] mb, input logic [31:0] n,
                       input logic [31:0] ctl);
    wr(ra(c, REG_CTRL), 32'h00000000);
    wr(ra(c, REG_PBASE), pb);
    wr(ra(c, REG_MBASE), mb);
    wr(ra(c, REG_COUNT), n);
    wr(ra(c, REG_CTRL), ctl);
  endtask

  initial
  begin
    #300000;
    miscompares++;
    results();
  end

  initial
  begin
    {psel, penable, pwrite} = 3'h0;
    paddr   = 12'h000;
    pwdata  = 32'h00000000;
    kick    = 8'h00;
    dly     = 4'h0;
    sys_rst = 1'b1;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(ra(7, REG_CTRL), 32'h00000000);
    rd(OFS_FLAGS, 32'h00000000);
    wr(ra(7, REG_CTRL), 32'hFFFFBFFE);
    rd(ra(7, REG_CTRL), 32'h00003F7E);
    wr(ra(7, REG_CTRL), 32'h00000000);
    apb(1'b0, 12'h0FC, 32'h00000000);
    chk({31'h0, e}, 32'h00000001);
    apb(1'b0, 12'h002, 32'h00000000);
    chk({31'h0, e}, 32'h00000001);
    // memory to memory, byte source widened to word
    for (int i = 0; i < 4; i++)
      u_ecdma_far_model.mem[32'h100 + i] = 32'hABCDEF10 + i;
    setup(0, 32'h200, 32'h100, 32'h4, 32'h426F);
    wait_log(4);
    for (int i = 0; i < 4; i++)
    begin
      chk(u_ecdma_far_model.wa[i], 32'h200 + 4 * i);
      chk(u_ecdma_far_model.wd[i], 32'h10 + i);
      chk({30'h0, u_ecdma_far_model.wz[i]}, {30'h0, W_WORD});
    end
    repeat (4) @(posedge mclk);
    rd(OFS_FLAGS, 32'h00000101);
    chk({24'h0, chan_irq}, 32'h00000001);
    rd(ra(0, REG_COUNT), 32'h00000000);
    rd(ra(0, REG_PBASE), 32'h00000200);
    wr(OFS_FLAGCLR, 32'h00000101);
    repeat (2) @(posedge mclk);
    chk({24'h0, chan_irq}, 32'h00000000);
    wr(ra(0, REG_CTRL), 32'h0000426E);
    rd(ra(0, REG_CTRL), 32'h0000426E);
    rd(ra(0, REG_MBASE), 32'h00000100);
    chk(32'(u_ecdma_far_model.wa.size()), 32'h4);
    // peripheral source, circular, slow bus
    u_ecdma_far_model.wa.delete();
    u_ecdma_far_model.wd.delete();
    u_ecdma_far_model.wz.delete();
    u_ecdma_far_model.mem[32'h300] = 32'h12345678;
    dly <= 4'h3;
    setup(2, 32'h300, 32'h400, 32'h2, 32'h0951);
    kick <= 8'h04;
    repeat (3) @(posedge mclk);
    kick <= 8'h00;
    wait_log(3);
    for (int i = 0; i < 3; i++)
    begin
      chk(u_ecdma_far_model.wa[i], (i == 1) ? 32'h404 : 32'h400);
      chk(u_ecdma_far_model.wd[i], 32'h00005678);
      chk({30'h0, u_ecdma_far_model.wz[i]}, {30'h0, W_WORD});
    end
    repeat (4) @(posedge mclk);
    // one item per request, and every request answered by an acknowledge
    chk(32'(u_ecdma_far_model.wa.size()), 32'h3);
    chk(32'(u_ecdma_far_model.pend[2]), 32'h0);
    rd(ra(2, REG_COUNT), 32'h00000001);
    rd(OFS_FLAGS, 32'h00000404);
    chk({24'h0, chan_irq}, 32'h00000000);
    rd(ra(2, REG_MBASE), 32'h00000400);
    wr(ra(2, REG_CTRL), 32'h00000950);
    // software triggers on channels 3 and 5 at once
    dly <= 4'h0;
    pt = '{'{PRI_LOW, PRI_HIGH}, '{PRI_MED, PRI_MED},
           '{PRI_VHIGH, PRI_HIGH}, '{PRI_MED, PRI_VHIGH}};
    first = '{32'h650, 32'h630, 32'h630, 32'h650};
    for (int k = 0; k < 4; k++)
    begin
      setup(3, 32'h630, 32'h530, 32'h1, {18'h0, pt[k][0], 12'h009});
      setup(5, 32'h650, 32'h550, 32'h1, {18'h0, pt[k][1], 12'h009});
      u_ecdma_far_model.wa.delete();
      u_ecdma_far_model.wz.delete();
      wr(OFS_SWTRIG, 32'h00000028);
      wait_log(2);
      chk(u_ecdma_far_model.wa[0], first[k]);
      chk(u_ecdma_far_model.wa[1], first[k] ^ 32'h060);
      chk({30'h0, u_ecdma_far_model.wz[0]}, {30'h0, W_BYTE});
    end
    results();
  end
endmodule
